/* include/mid_pkg.sv */
// Package holding instruction encodings, constants, reset values and carrier structs for the decoder
// What this block does
// - Byte ops store result to accumulator when destination bit is 0, else file.
// - Don't-care opcode bits are ignored; either value is accepted.
// - Byte sub-field 0111 adds accumulator and file, updates carry, half carry, zero.
// - Byte sub-field 0101 ANDs accumulator with file, updates zero only.
// - Add-literal sums accumulator with 8-bit immediate, updates carry, half carry, zero.
// - Literal sub-field 1001 ANDs accumulator with immediate, updates zero only.
// - Bit clear and bit set force one file bit, flags untouched.
// - Bit tests skip the next instruction on match, taking two cycles.
// - Call pushes return address, loads 11-bit target plus upper latch bits, two cycles.
// - Watchdog kick clears watchdog and prescaler, sets timeout and powerdown flags.
// - Clear-file writes zero to the file register and sets zero flag.
// - Clear-accumulator writes zero to accumulator and sets zero flag.
// - Byte sub-field 1001 inverts the file register, updates zero flag.
// - Byte sub-field 0011 decrements the file register, updates zero flag.
// - Decrement/increment-and-skip store result and skip on zero, flags untouched.
// - Program counter changes or true tests take two cycles, second is a no-op.
// - Writing the timer-zero count clears the prescaler when assigned to timer zero.
// - Read-modify-write on a port reads pin levels, not the output latch.
// - Standby takes one cycle and affects timeout and powerdown flags.
// - Every instruction is one 14-bit word of opcode and operands.
// - Standby clears watchdog and prescaler, sets timeout, clears powerdown, halts clock.
// - Return-from-interrupt pops the stack into the counter, sets global enable, two cycles.
// - One instruction cycle spans four oscillator periods.
package mid_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned QUARTERS = 4;
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PCL_ADDR = 7'h02;
  localparam logic [6:0] PORT_ADDR = 7'h05;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRF = 4'hC;
  localparam logic [3:0] OP_RLF = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [7:0] MISC_RETURN = 8'h08;
  localparam logic [7:0] MISC_IRQ_RET = 8'h09;
  localparam logic [7:0] MISC_SLEEP = 8'h63;
  localparam logic [7:0] MISC_KICK = 8'h64;

  typedef enum logic [1:0] {MID_BIT_CLEAR, MID_BIT_SET, MID_BIT_TEST_CLEAR, MID_BIT_TEST_SET} mid_bitop_t;

  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
  } mid_alu_flags_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } mid_file_wr_t;
endpackage

/* hdl/mid_core.sv */
// Decode and execute core for the 14-bit instruction set
`timescale 1ns/1ps
module mid_core (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic [13:0] insn_i,
  input wire logic [7:0] file_rd_i,
  input wire logic [7:0] port_pins_i,
  input wire logic [4:0] upper_pc_latch_reg_i,
  input wire logic psa_to_timer_i,
  output logic [12:0] pc_o,
  output logic [6:0] file_addr_o,
  output logic file_we_o,
  output logic [7:0] file_wr_o,
  output logic [7:0] accum_o,
  output logic carry_o,
  output logic half_carry_o,
  output logic zero_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic global_irq_enable_o,
  output logic wdt_clear_o,
  output logic prescaler_clear_o,
  output logic sleep_o,
  output logic q_phase_end_o
);
  // Quarter-phase counter: one instruction cycle is four oscillator periods
  logic [1:0] qph_q;
  wire cycle_end = clk_en_i && (qph_q == 2'(mid_pkg::QUARTERS - 1));
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) qph_q <= 2'h0;
    else if (clk_en_i) qph_q <= qph_q + 2'h1;
  end

  // Register file address from a flop; settles one clock into the cycle, well before use
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) file_addr_o <= 7'h00;
    else if (clk_en_i) file_addr_o <= insn_i[6:0];
  end

  // field split of the 14-bit word
  wire [1:0] cls = insn_i[13:12];
  wire [3:0] sub = insn_i[11:8];
  wire dbit = insn_i[7];
  wire [2:0] bsel = insn_i[9:7];
  wire [7:0] lit = insn_i[7:0];
  wire [6:0] faddr = insn_i[6:0];

  logic [7:0] w_q;
  logic c_q, hc_q, z_q, timeout_q, powerdown_q, irq_en_q, flush_q, hold_q, sleep_q;
  logic [12:0] pc_q;
  logic [12:0] stack_q [mid_pkg::STACK_DEPTH];
  logic [2:0] sp_q;

  // port reads use pin levels rather than the latch
  wire [7:0] fval = (faddr == mid_pkg::PORT_ADDR) ? port_pins_i : file_rd_i;

  // Class decode; the flush cycle turns any word into a no-op
  wire live = !flush_q && !sleep_q;
  wire is_byte = live && (cls == 2'b00);
  wire is_bit = live && (cls == 2'b01);
  wire is_ctl = live && (cls == 2'b10);
  wire is_lit = live && (cls == 2'b11);
  wire is_misc = is_byte && (sub == mid_pkg::OP_MISC) && !dbit;
  wire is_movwf = is_byte && (sub == mid_pkg::OP_MISC) && dbit;
  wire is_ret = is_misc && (lit == mid_pkg::MISC_RETURN);
  wire is_irq_ret = is_misc && (lit == mid_pkg::MISC_IRQ_RET);
  wire is_sleep = is_misc && (lit == mid_pkg::MISC_SLEEP);
  wire is_kick = is_misc && (lit == mid_pkg::MISC_KICK);
  wire is_call = is_ctl && !insn_i[11];
  wire is_goto = is_ctl && insn_i[11];
  wire is_retlw = is_lit && (insn_i[11:10] == 2'b01);

  // Byte-class arithmetic
  wire [8:0] add_f = {1'b0, w_q} + {1'b0, fval};
  wire [4:0] add_f_lo = {1'b0, w_q[3:0]} + {1'b0, fval[3:0]};
  wire [8:0] sub_f = {1'b0, fval} + {1'b0, ~w_q} + 9'h001;
  wire [4:0] sub_f_lo = {1'b0, fval[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
  wire [7:0] dec_v = fval - 8'h01;
  wire [7:0] inc_v = fval + 8'h01;

  logic [7:0] bres;
  logic bc, bdc, bc_we, bdc_we, bz_we;
  // Byte operation result mux and flag effects
  always_comb begin
    bres = fval;
    bc = c_q;
    bdc = hc_q;
    bc_we = 1'b0;
    bdc_we = 1'b0;
    bz_we = 1'b1;
    case (sub)
      mid_pkg::OP_ADD: begin
        bres = add_f[7:0]; bc = add_f[8]; bdc = add_f_lo[4]; bc_we = 1'b1; bdc_we = 1'b1;
      end
      mid_pkg::OP_SUB: begin
        bres = sub_f[7:0]; bc = sub_f[8]; bdc = sub_f_lo[4]; bc_we = 1'b1; bdc_we = 1'b1;
      end
      mid_pkg::OP_AND: bres = w_q & fval;
      mid_pkg::OP_IOR: bres = w_q | fval;
      mid_pkg::OP_XOR: bres = w_q ^ fval;
      mid_pkg::OP_COM: bres = ~fval;
      mid_pkg::OP_DEC: bres = dec_v;
      mid_pkg::OP_INC: bres = inc_v;
      mid_pkg::OP_DECSZ: begin
        bres = dec_v; bz_we = 1'b0;
      end
      mid_pkg::OP_INCSZ: begin
        bres = inc_v; bz_we = 1'b0;
      end
      mid_pkg::OP_RRF: begin
        bres = {c_q, fval[7:1]}; bc = fval[0]; bc_we = 1'b1; bz_we = 1'b0;
      end
      mid_pkg::OP_RLF: begin
        bres = {fval[6:0], c_q}; bc = fval[7]; bc_we = 1'b1; bz_we = 1'b0;
      end
      mid_pkg::OP_SWAP: begin
        bres = {fval[3:0], fval[7:4]}; bz_we = 1'b0;
      end
      // clear-file / clear-accumulator both give zero
      mid_pkg::OP_CLR: bres = 8'h00;
      mid_pkg::OP_MOV: bres = fval;
      default: begin
        bres = w_q; bz_we = 1'b0;
      end
    endcase
  end

  // Literal-class arithmetic
  wire [8:0] add_l = {1'b0, w_q} + {1'b0, lit};
  wire [4:0] add_l_lo = {1'b0, w_q[3:0]} + {1'b0, lit[3:0]};
  wire [8:0] sub_l = {1'b0, lit} + {1'b0, ~w_q} + 9'h001;
  wire [4:0] sub_l_lo = {1'b0, lit[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
  logic [7:0] lres;
  logic lc, ldc, lc_we, lz_we;
  // Literal operation mux
  always_comb begin
    lres = lit;
    lc = add_l[8];
    ldc = add_l_lo[4];
    lc_we = 1'b0;
    lz_we = 1'b1;
    case (insn_i[11:8])
      4'hE, 4'hF: begin
        lres = add_l[7:0]; lc_we = 1'b1;
      end
      4'hC, 4'hD: begin
        lres = sub_l[7:0]; lc = sub_l[8]; ldc = sub_l_lo[4]; lc_we = 1'b1;
      end
      4'h9: lres = w_q & lit;
      4'h8: lres = w_q | lit;
      4'hA: lres = w_q ^ lit;
      default: begin
        lres = lit; lz_we = 1'b0;
      end
    endcase
  end

  // bit clear and set act on one bit only
  logic [7:0] bitres;
  always_comb begin
    bitres = fval;
    bitres[bsel] = insn_i[10];
  end
  wire bit_wr = is_bit && !insn_i[11];
  // skip when tested bit matches the sense
  wire bit_skip = is_bit && insn_i[11] && (fval[bsel] == insn_i[10]);
  wire sz_skip = is_byte && ((sub == mid_pkg::OP_DECSZ) || (sub == mid_pkg::OP_INCSZ)) && (bres == 8'h00);

  // destination bit routes byte results; move-accumulator-to-file always writes file, clear with destination 0 never does
  wire byte_to_file = is_byte && !is_misc && (dbit || is_movwf) && !(sub == mid_pkg::OP_CLR && !dbit);
  wire byte_to_w = is_byte && !dbit && sub != mid_pkg::OP_MISC;
  wire [7:0] byte_wdata = is_movwf ? w_q : bres;
  wire f_we = byte_to_file || bit_wr;
  wire [7:0] f_data = is_bit ? bitres : byte_wdata;
  wire flags_byte = is_byte && !is_misc && !is_movwf;
  // taken branch or skip forces a no-op cycle
  wire pc_jump = is_call || is_goto || is_ret || is_irq_ret || is_retlw;
  wire pcl_wr = f_we && (faddr == mid_pkg::PCL_ADDR);
  // A load flushes the target word itself, so the counter must hold through the no-op
  wire pc_load = pc_jump || pcl_wr;
  wire flush_d = pc_load || bit_skip || sz_skip;
  wire [12:0] pc_inc = pc_q + 13'h0001;
  // target low bits from the word, upper from the page latch
  wire [12:0] jmp_tgt = {upper_pc_latch_reg_i[4:3], insn_i[10:0]};
  wire [12:0] tos = stack_q[3'(sp_q - 3'h1)];
  wire [12:0] pc_d = (is_call || is_goto) ? jmp_tgt
                   : (is_ret || is_irq_ret || is_retlw) ? tos
                   : pcl_wr ? {upper_pc_latch_reg_i, f_data}
                   : pc_inc;
  // prescaler cleared on timer-zero writes when assigned to it
  wire tmr_hit = f_we && (faddr == mid_pkg::TIMER_ZERO_ADDR) && psa_to_timer_i;

  // Architectural state, updated once per instruction cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_q <= mid_pkg::RESET_VECTOR;
      w_q <= 8'h00;
      {c_q, hc_q, z_q} <= 3'h0;
      timeout_q <= 1'b1;
      powerdown_q <= 1'b1;
      irq_en_q <= 1'b0;
      flush_q <= 1'b0;
      hold_q <= 1'b0;
      sleep_q <= 1'b0;
      sp_q <= 3'h0;
    end else if (cycle_end) begin
      // Hold after a load, else the flushed target word would be stepped over
      pc_q <= (sleep_q || hold_q) ? pc_q : pc_d;
      flush_q <= flush_d;
      hold_q <= pc_load;
      if (byte_to_w) w_q <= bres;
      if (is_lit) w_q <= lres;
      if (flags_byte && bc_we) c_q <= bc;
      if (flags_byte && bdc_we) hc_q <= bdc;
      if (flags_byte && bz_we) z_q <= (bres == 8'h00);
      if (is_lit && lc_we) {c_q, hc_q} <= {lc, ldc};
      if (is_lit && lz_we) z_q <= (lres == 8'h00);
      if (is_kick) {timeout_q, powerdown_q} <= 2'b11;
      // standby one cycle / timeout set, powerdown cleared, halt
      if (is_sleep) begin
        timeout_q <= 1'b1;
        powerdown_q <= 1'b0;
        sleep_q <= 1'b1;
      end
      // return from interrupt sets global enable
      if (is_irq_ret) irq_en_q <= 1'b1;
      if (is_call) sp_q <= sp_q + 3'h1;
      if (is_ret || is_irq_ret || is_retlw) sp_q <= sp_q - 3'h1;
    end
  end

  // Stack entries, one flop group per level; depth wraps as a circular buffer
  for (genvar i = 0; i < mid_pkg::STACK_DEPTH; i++) begin : g_stack
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) stack_q[i] <= 13'h0000;
      else if (cycle_end && is_call && sp_q == 3'(i)) stack_q[i] <= pc_inc;
    end
  end

  // Registered outputs; strobes are one clock wide at the cycle boundary
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      file_we_o <= 1'b0;
      file_wr_o <= 8'h00;
      wdt_clear_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
      q_phase_end_o <= 1'b0;
    end else if (clk_en_i) begin
      file_we_o <= cycle_end && f_we;
      file_wr_o <= f_data;
      wdt_clear_o <= cycle_end && (is_kick || is_sleep);
      prescaler_clear_o <= cycle_end && (is_kick || is_sleep || tmr_hit);
      q_phase_end_o <= cycle_end;
    end
  end

  assign pc_o = pc_q;
  assign accum_o = w_q;
  assign carry_o = c_q;
  assign half_carry_o = hc_q;
  assign zero_o = z_q;
  assign timeout_flag_o = timeout_q;
  assign powerdown_flag_o = powerdown_q;
  assign global_irq_enable_o = irq_en_q;
  assign sleep_o = sleep_q;

  // Checks beside the logic
  a_skip_flush: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && bit_skip |=> flush_q) else $error("skip did not flush");
  a_call_two: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && is_call |=> flush_q && pc_q == $past(jmp_tgt)) else $error("call wrong");
  a_kick_flags: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && is_kick |=> timeout_q && powerdown_q && wdt_clear_o) else $error("kick flags");
  a_sleep_flags: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && is_sleep |=> timeout_q && !powerdown_q && sleep_q) else $error("sleep flags");
  a_clr_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && is_byte && sub == mid_pkg::OP_CLR |=> z_q) else $error("clear zero");
  a_and_carry: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && is_lit && insn_i[11:8] == 4'h9 |=> $stable(c_q)) else $error("and carry");
  a_tmr_presc: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && tmr_hit |=> prescaler_clear_o) else $error("prescaler");
  a_irq_ret_enable: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && is_irq_ret |=> irq_en_q && flush_q) else $error("interrupt return");
  a_cycle_four: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end |=> !cycle_end [*3]) else $error("cycle length");
  a_jump_hold: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cycle_end && hold_q |=> $stable(pc_q)) else $error("target skipped");
  c_call: cover property (@(posedge clk_sys_i) cycle_end && is_call);
  c_skip: cover property (@(posedge clk_sys_i) cycle_end && sz_skip);
  c_sleep: cover property (@(posedge clk_sys_i) cycle_end && is_sleep);
endmodule

/* dv/mid_prog_mem.sv */
// Program memory model that feeds instruction words to the decode core
`timescale 1ns/1ps
module mid_prog_mem (
  input wire logic clk_sys_i,
  input wire logic [12:0] pc_i,
  output logic [13:0] insn_o
);
  logic [13:0] mem_q [0:8191];
  logic [13:0] word_q = 14'h0000;

  // one whole word
  // Refetch on the falling edge so the word is steady over every sampling edge
  always @(negedge clk_sys_i) begin
    word_q <= mem_q[pc_i];
  end
  assign insn_o = word_q;
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the decode and execute core
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] port_pins = 8'h00;
  logic [4:0] upper_latch = 5'h00;
  logic psa = 1'b0;
  logic [7:0] file_q [0:127];
  logic [13:0] insn;
  logic [12:0] pc;
  logic [6:0] file_addr;
  logic [7:0] file_wr;
  logic [7:0] accum;
  logic file_we, carry, half_carry, zero, timeout_flag, powerdown_flag, irq_en;
  logic wdt_clear, pre_clear, sleep, q_end;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  // File register read port, combinational as the core expects
  wire logic [7:0] file_rd = file_q[file_addr];

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  mid_core u_mid_core (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en), .insn_i(insn),
    .file_rd_i(file_rd), .port_pins_i(port_pins), .upper_pc_latch_reg_i(upper_latch),
    .psa_to_timer_i(psa), .pc_o(pc), .file_addr_o(file_addr), .file_we_o(file_we), .file_wr_o(file_wr),
    .accum_o(accum), .carry_o(carry), .half_carry_o(half_carry), .zero_o(zero),
    .timeout_flag_o(timeout_flag), .powerdown_flag_o(powerdown_flag), .global_irq_enable_o(irq_en),
    .wdt_clear_o(wdt_clear), .prescaler_clear_o(pre_clear), .sleep_o(sleep), .q_phase_end_o(q_end));

  mid_prog_mem u_mid_prog_mem (.clk_sys_i(clk_sys_i), .pc_i(pc), .insn_o(insn));

  task automatic give_verdict();
    $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp_bit(input logic exp, input logic got);
    cmp_val(16'(exp), 16'(got));
  endtask

  // Reset falls and rises on falling edges, held two cycles
  task automatic restart();
    @(negedge clk_sys_i);
    arst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
  endtask

  // One instruction cycle; returns once the cycle-end pulse is settled
  task automatic step();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (q_end !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    // Return on the falling edge so callers drive inputs there; pulses still stand
    @(negedge clk_sys_i);
  endtask

  task automatic clear_prog();
    for (int i = 0; i < 8192; i++) u_mid_prog_mem.mem_q[i] = 14'h0000;
  endtask

  // Arithmetic and logic chain: {word, accum, carry/half/zero, write, data}
  task automatic test_alu();
    logic [33:0] tbl [13] = '{{14'h3E8F, 8'h8F, 3'h0, 1'b0, 8'h00}, {14'h07A0, 8'h8F, 3'h7, 1'b1, 8'h00},
      {14'h0520, 8'h01, 3'h6, 1'b0, 8'h00}, {14'h0720, 8'h72, 3'h0, 1'b0, 8'h00},
      {14'h398D, 8'h00, 3'h1, 1'b0, 8'h00}, {14'h3FFF, 8'hFF, 3'h0, 1'b0, 8'h00},
      {14'h09A0, 8'hFF, 3'h0, 1'b1, 8'h8E}, {14'h0320, 8'h70, 3'h0, 1'b0, 8'h00},
      {14'h017F, 8'h00, 3'h1, 1'b0, 8'h00}, {14'h3E01, 8'h01, 3'h0, 1'b0, 8'h00},
      {14'h01A0, 8'h01, 3'h1, 1'b1, 8'h00}, {14'h17A0, 8'h01, 3'h1, 1'b1, 8'hF1},
      {14'h1020, 8'h01, 3'h1, 1'b1, 8'h70}};
    file_q[7'h20] = 8'h71;
    for (int i = 0; i < 13; i++) u_mid_prog_mem.mem_q[i] = tbl[i][33:20];
    restart();
    for (int i = 0; i < 13; i++) begin
      step();
      cmp_val(16'(tbl[i][19:12]), 16'(accum));
      cmp_val(16'(tbl[i][11:9]), 16'({carry, half_carry, zero}));
      cmp_bit(tbl[i][8], file_we);
      if (tbl[i][8]) cmp_val(16'(tbl[i][7:0]), 16'(file_wr));
    end
  endtask

  // Skip cases: {word, file value, skip, write, data}; skipped add of 1 shows in accum
  task automatic test_skip();
    logic [31:0] tbl [8] = '{{14'h1820, 8'hFE, 1'b1, 1'b0, 8'h00}, {14'h1820, 8'h01, 1'b0, 1'b0, 8'h00},
      {14'h1FA0, 8'h80, 1'b1, 1'b0, 8'h00}, {14'h1FA0, 8'h7F, 1'b0, 1'b0, 8'h00},
      {14'h0BA0, 8'h01, 1'b1, 1'b1, 8'h00}, {14'h0BA0, 8'h02, 1'b0, 1'b1, 8'h01},
      {14'h0FA0, 8'hFF, 1'b1, 1'b1, 8'h00}, {14'h0FA0, 8'h00, 1'b0, 1'b1, 8'h01}};
    u_mid_prog_mem.mem_q[1] = 14'h3E01;
    u_mid_prog_mem.mem_q[2] = 14'h3E02;
    for (int i = 0; i < 8; i++) begin
      u_mid_prog_mem.mem_q[0] = tbl[i][31:18];
      file_q[7'h20] = tbl[i][17:10];
      restart();
      step();
      cmp_bit(tbl[i][8], file_we);
      if (tbl[i][8]) cmp_val(16'(tbl[i][7:0]), 16'(file_wr));
      repeat (2) step();
      cmp_val(tbl[i][9] ? 16'h0002 : 16'h0003, 16'(accum));
    end
  endtask

  // Call to the top of a page, then return from interrupt
  task automatic test_call();
    u_mid_prog_mem.mem_q[0] = 14'h27FF;
    u_mid_prog_mem.mem_q[13'h17FF] = 14'h0009;
    upper_latch = 5'b10100;
    restart();
    step();
    cmp_val(16'h17FF, 16'(pc));
    step();
    cmp_val(16'h17FF, 16'(pc));
    cmp_bit(1'b0, irq_en);
    step();
    cmp_val(16'h0001, 16'(pc));
    cmp_bit(1'b1, irq_en);
  endtask

  // Port read, timer prescaler, watchdog kick, standby
  task automatic test_misc();
    u_mid_prog_mem.mem_q[0] = 14'h0905;
    u_mid_prog_mem.mem_q[1] = 14'h0181;
    u_mid_prog_mem.mem_q[2] = 14'h0181;
    u_mid_prog_mem.mem_q[3] = 14'h0064;
    u_mid_prog_mem.mem_q[4] = 14'h0063;
    u_mid_prog_mem.mem_q[5] = 14'h3E01;
    file_q[7'h05] = 8'h00;
    port_pins = 8'hA5;
    psa = 1'b0;
    restart();
    step();
    cmp_val(16'h005A, 16'(accum));
    // Enable low must freeze the core
    @(negedge clk_sys_i);
    clk_en = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    cmp_val(16'h0001, 16'(pc));
    clk_en = 1'b1;
    step();
    cmp_bit(1'b0, pre_clear);
    @(negedge clk_sys_i);
    psa = 1'b1;
    step();
    cmp_bit(1'b1, pre_clear);
    step();
    cmp_val(16'h000F, 16'({wdt_clear, pre_clear, timeout_flag, powerdown_flag}));
    step();
    cmp_val(16'h000E, 16'({sleep, wdt_clear, timeout_flag, powerdown_flag}));
    repeat (12) @(posedge clk_sys_i);
    #1;
    cmp_val(16'h005A, 16'(accum));
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    for (int i = 0; i < 128; i++) file_q[i] = 8'h00;
    clear_prog();
    test_alu();
    clear_prog();
    test_skip();
    clear_prog();
    test_call();
    clear_prog();
    test_misc();
    give_verdict();
  end
endmodule
